/* rtl/fbe_consts.vh */
// Constants for the on-board flash programming entry block.
// Assumes a 100 MHz system clock; included by the design files by bare name.
`ifndef FBE_CONSTS_VH
`define FBE_CONSTS_VH

`define FBE_CLK_MHZ 100
// Register offsets
`define FBE_OFS_CTRL_LOWER 8'h80
`define FBE_OFS_CTRL_UPPER 8'h81
`define FBE_OFS_STATUS 8'h82
`define FBE_OFS_DIVISOR 8'h83
`define FBE_OFS_BOOT_CTRL 8'h84
// Flash control field positions
`define FBE_BIT_PROG 0
`define FBE_BIT_ERASE 1
`define FBE_BIT_PVERIFY 2
`define FBE_BIT_EVERIFY 3
`define FBE_BIT_PSETUP 4
`define FBE_BIT_ESETUP 5
`define FBE_BIT_SWE 6
// Status field positions
`define FBE_ST_BOOT 0
`define FBE_ST_SINGLE 1
`define FBE_ST_MULT_LO 2
`define FBE_ST_ONBOARD 4
`define FBE_ST_WP 5
`define FBE_ST_BRANCHED 6
`define FBE_ST_FLASH_BUSY 7
// Reset values
`define FBE_CTRL_RESET 8'h00
`define FBE_DIV_RESET 16'h0000
// Multiplier codes from the upper mode pins
`define FBE_MULT_X1 2'h0
`define FBE_MULT_X2 2'h1
`define FBE_MULT_X4 2'h2
// Boot sequence bytes
`define FBE_BYTE_SYNC 8'h00
`define FBE_BYTE_ACK 8'h55
// Low period of a zero character in bit times
`define FBE_LOW_BITS 20'h00009
// Software write enable settle time
`define FBE_SWE_WAIT_US 10
`define FBE_SWE_WAIT_CYC (`FBE_SWE_WAIT_US * `FBE_CLK_MHZ)
// Last count of the settle wait, 1000 cycles at 100 MHz
`define FBE_SWE_LAST 13'h03E7
// Cycles after reset release before the pin synchronisers hold pin levels
`define FBE_LATCH_WAIT 2'h2
// Control program region start in RAM
`define FBE_RAM_PROG_START 16'h0800
`define FBE_RAM_LOADER_END 16'h07FF

`endif

/* rtl/fbe_uart.v */
// Asynchronous serial transceiver, 8 data bits, 1 stop bit, no parity.
// Assumes rx already synchronised to clock; divisor is cycles per bit.
`timescale 1ns/1ps
`include "fbe_consts.vh"

module fbe_uart (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Bit timing
  input wire [15:0] divisor,
  // Serial lines
  input wire rx,
  output reg tx,
  // Receive side
  output reg rx_valid,
  output reg [7:0] rx_data,
  // Transmit side
  input wire tx_start,
  input wire [7:0] tx_data,
  output reg tx_busy
);

  reg [15:0] rx_cnt;
  reg [3:0] rx_bit;
  reg rx_act;
  reg [7:0] rx_sh;
  reg [15:0] tx_cnt;
  reg [3:0] tx_bit;
  reg [9:0] tx_sh;

  // Receive: sample mid-bit, frame of 10 bits
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_cnt <= 16'h0000;
      rx_bit <= 4'h0;
      rx_act <= 1'b0;
      rx_sh <= 8'h00;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_act) begin
        if (!rx && divisor != 16'h0000) begin
          rx_act <= 1'b1;
          rx_bit <= 4'h0;
          rx_cnt <= {1'b0, divisor[15:1]};
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= divisor - 16'h0001;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx) begin
          rx_act <= 1'b0;
        end else if (rx_bit >= 4'h1 && rx_bit <= 4'h8) begin
          rx_sh <= {rx, rx_sh[7:1]};
        end else if (rx_bit == 4'h9) begin
          rx_act <= 1'b0;
          if (rx) begin
            rx_valid <= 1'b1;
            rx_data <= rx_sh;
          end
        end
      end
    end
  end

  // Transmit: start, 8 data LSB first, stop
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx <= 1'b1;
      tx_busy <= 1'b0;
      tx_cnt <= 16'h0000;
      tx_bit <= 4'h0;
      tx_sh <= 10'h3FF;
    end else if (!tx_busy) begin
      tx <= 1'b1;
      if (tx_start) begin
        tx_busy <= 1'b1;
        tx_sh <= {1'b1, tx_data, 1'b0};
        tx_bit <= 4'h0;
        tx_cnt <= 16'h0000;
      end
    end else if (tx_cnt != 16'h0000) begin
      tx_cnt <= tx_cnt - 16'h0001;
    end else if (tx_bit == 4'hA) begin
      tx_busy <= 1'b0;
      tx <= 1'b1;
    end else begin
      tx <= tx_sh[0];
      tx_sh <= {1'b1, tx_sh[9:1]};
      tx_bit <= tx_bit + 4'h1;
      tx_cnt <= divisor - 16'h0001;
    end
  end

endmodule // fbe_uart

/* rtl/fbe_entry.v */
// On-board flash programming entry: mode pin decode, boot loader, flash control.
// Assumes pins are asynchronous; registers reached over a simple strobe port.
//
// What this block does
// - At power-on reset decode mode pins: boot/user, single/expanded, multiplier.
// - Enter on-board programming state only on pin setting plus power-on reset.
// - Boot mode loads the control program over serial channel 1 into RAM.
// - After the program transfer completes, branch to the RAM program start.
// - Host sends zero bytes; device measures low period to derive bit rate.
// - Serial format is 8 data bits, one stop bit, no parity.
// - After adjustment the device transmits one zero byte.
// - Adjustment supported only within stated system clock ranges.
// - RAM split into loader and program regions; loader region locked until branch.
// - Loader code stays in its RAM region after the branch.
// - Flash array unreadable while program or erase is in progress.
// - Program, erase and verify modes via lower and upper control registers.
// - No programming or erasing while the write-protect pin is high.
// - On non-flash variants control register reads return zero.
`timescale 1ns/1ps
`include "fbe_consts.vh"

module fbe_entry #(
  parameter FLASH_PRESENT = 1,
  parameter PROG_LEN = 16'h0100
) (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Mode pins
  input wire flash_write_protect_pin,
  input wire mode_select_pin3,
  input wire mode_select_pin2,
  input wire mode_select_pin1,
  input wire mode_select_pin0,
  // Serial channel pins
  input wire serial_rxd,
  output reg serial_txd,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // RAM write port
  output reg ram_we,
  output reg [15:0] ram_addr,
  output reg [7:0] ram_wdata,
  // Processor and flash side
  input wire cpu_pc_in_flash,
  input wire [15:0] cpu_ram_addr,
  output reg ram_loader_locked,
  output reg cpu_branch,
  output reg [15:0] cpu_branch_addr,
  output reg flash_read_block,
  output reg [7:0] flash_ctrl_lower,
  output reg [7:0] flash_ctrl_upper,
  output reg swe_ready
);

  localparam ST_IDLE = 6'b000001;
  localparam ST_MEAS = 6'b000010;
  localparam ST_SEND = 6'b000100;
  localparam ST_WACK = 6'b001000;
  localparam ST_LOAD = 6'b010000;
  localparam ST_RUN = 6'b100000;

  reg [4:0] pin_s1;
  reg [4:0] pin_s2;
  reg rx_s1;
  reg rx_s2;
  reg [3:0] mode;
  reg latched;
  reg onboard;
  reg [1:0] latch_wait;
  reg [5:0] state;
  reg [5:0] next_state;
  reg [19:0] low_cnt;
  reg [15:0] divisor;
  reg rx_prev;
  reg [15:0] load_cnt;
  reg tx_start;
  reg [12:0] swe_cnt;
  reg [7:0] status;
  wire rx_valid;
  wire [7:0] rx_data;
  wire tx_busy;
  wire uart_tx;
  wire boot_mode;
  wire wp_high;
  wire flash_busy;
  wire in_flash_ok;
  wire [19:0] low_div;
  wire rx_fall;
  wire rx_rise;

  assign boot_mode = ~mode[1];
  assign wp_high = pin_s2[4];
  assign in_flash_ok = ~cpu_pc_in_flash;
  assign flash_busy = flash_ctrl_lower[`FBE_BIT_PROG] | flash_ctrl_lower[`FBE_BIT_ERASE] |
                      flash_ctrl_upper[`FBE_BIT_PROG] | flash_ctrl_upper[`FBE_BIT_ERASE];
  // Receive line edges for the low-run timer
  assign rx_fall = ~rx_s2 & rx_prev;
  assign rx_rise = rx_s2 & ~rx_prev;
  // Cycles per bit from a low run of start plus eight zero bits
  assign low_div = low_cnt / `FBE_LOW_BITS;

  // Pin synchronisers
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      pin_s1 <= {flash_write_protect_pin, mode_select_pin3, mode_select_pin2,
                 mode_select_pin1, mode_select_pin0};
      pin_s2 <= pin_s1;
      rx_s1 <= serial_rxd;
      rx_s2 <= rx_s1;
    end
  end

  // Mode latch once both synchroniser stages hold real pin levels
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= 4'h0;
      latched <= 1'b0;
      onboard <= 1'b0;
      latch_wait <= 2'h0;
    end else if (!latched) begin
      if (latch_wait == `FBE_LATCH_WAIT) begin
        latched <= 1'b1;
        mode <= pin_s2[3:0];
        onboard <= ~pin_s2[4] & (pin_s2[3:2] != 2'h3);
      end else begin
        latch_wait <= latch_wait + 2'h1;
      end
    end
  end

  fbe_uart u_uart (
    .clock(clock),
    .sys_rst(sys_rst),
    .divisor(divisor),
    .rx(rx_s2),
    .tx(uart_tx),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .tx_start(tx_start),
    .tx_data(`FBE_BYTE_SYNC),
    .tx_busy(tx_busy)
  );

  // Boot sequencer next state
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (latched && onboard && boot_mode) next_state = ST_MEAS;
      end
      ST_MEAS: begin
        if (rx_rise && low_cnt != 20'h00000) next_state = ST_SEND;
      end
      ST_SEND: begin
        if (tx_start) next_state = ST_WACK;
      end
      ST_WACK: begin
        if (rx_valid && rx_data == `FBE_BYTE_ACK) next_state = ST_LOAD;
      end
      ST_LOAD: begin
        if (load_cnt == PROG_LEN) next_state = ST_RUN;
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Boot sequencer datapath
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      low_cnt <= 20'h00000;
      divisor <= `FBE_DIV_RESET;
      rx_prev <= 1'b1;
      load_cnt <= 16'h0000;
      tx_start <= 1'b0;
      ram_we <= 1'b0;
      ram_addr <= 16'h0000;
      ram_wdata <= 8'h00;
      cpu_branch <= 1'b0;
      cpu_branch_addr <= 16'h0000;
      ram_loader_locked <= 1'b0;
      serial_txd <= 1'b1;
    end else begin
      state <= next_state;
      rx_prev <= rx_s2;
      tx_start <= 1'b0;
      ram_we <= 1'b0;
      cpu_branch <= 1'b0;
      serial_txd <= uart_tx;
      ram_loader_locked <= boot_mode & onboard & (state != ST_RUN);
      if (state == ST_MEAS) begin
        if (rx_fall) low_cnt <= 20'h00001;
        else if (!rx_s2 && low_cnt != 20'hFFFFF) low_cnt <= low_cnt + 20'h00001;
        else if (rx_rise) divisor <= low_div[15:0];
      end
      if (state == ST_SEND && !tx_busy && !tx_start) tx_start <= 1'b1;
      if (state == ST_LOAD && rx_valid) begin
        ram_we <= 1'b1;
        ram_addr <= `FBE_RAM_PROG_START + load_cnt;
        ram_wdata <= rx_data;
        load_cnt <= load_cnt + 16'h0001;
      end
      if (state == ST_LOAD && next_state == ST_RUN) begin
        cpu_branch <= 1'b1;
        cpu_branch_addr <= `FBE_RAM_PROG_START;
      end
    end
  end

  // Flash control registers and write enable timer
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      flash_ctrl_lower <= `FBE_CTRL_RESET;
      flash_ctrl_upper <= `FBE_CTRL_RESET;
      swe_cnt <= 13'h0000;
      swe_ready <= 1'b0;
      flash_read_block <= 1'b0;
    end else begin
      flash_read_block <= flash_busy;
      if (!flash_ctrl_lower[`FBE_BIT_SWE]) begin
        swe_cnt <= 13'h0000;
        swe_ready <= 1'b0;
      end else if (swe_cnt == `FBE_SWE_LAST) begin
        swe_ready <= 1'b1;
      end else begin
        swe_cnt <= swe_cnt + 13'h0001;
      end
      if (wp_high || !onboard) begin
        flash_ctrl_lower[5:0] <= 6'h00;
        flash_ctrl_upper[5:0] <= 6'h00;
      end
      if (reg_wr && in_flash_ok && onboard && !wp_high && FLASH_PRESENT != 0) begin
        if (reg_addr == `FBE_OFS_CTRL_LOWER) begin
          flash_ctrl_lower <= reg_wdata & 8'h7F;
        end else if (reg_addr == `FBE_OFS_CTRL_UPPER) begin
          flash_ctrl_upper <= reg_wdata & 8'h3F;
        end
      end
    end
  end

  // Status word
  always @* begin
    status = 8'h00;
    status[`FBE_ST_BOOT] = boot_mode;
    status[`FBE_ST_SINGLE] = mode[0];
    status[`FBE_ST_MULT_LO +: 2] = mode[3:2];
    status[`FBE_ST_ONBOARD] = onboard;
    status[`FBE_ST_WP] = wp_high;
    status[`FBE_ST_BRANCHED] = (state == ST_RUN);
    status[`FBE_ST_FLASH_BUSY] = flash_busy;
  end

  // Register read port, data one cycle after strobe
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (FLASH_PRESENT == 0) begin
        reg_rdata <= 16'h0000;
      end else if (reg_addr == `FBE_OFS_CTRL_LOWER) begin
        reg_rdata <= {8'h00, flash_ctrl_lower};
      end else if (reg_addr == `FBE_OFS_CTRL_UPPER) begin
        reg_rdata <= {8'h00, flash_ctrl_upper};
      end else if (reg_addr == `FBE_OFS_STATUS) begin
        reg_rdata <= {8'h00, status};
      end else if (reg_addr == `FBE_OFS_DIVISOR) begin
        reg_rdata <= divisor;
      end else if (reg_addr == `FBE_OFS_BOOT_CTRL) begin
        reg_rdata <= load_cnt;
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // fbe_entry

/* test/fbe_entry_props.sv */
// Checker for the flash programming entry block, bound to its ports.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
module fbe_entry_props #(
  parameter PROG_LEN = 16'h0100
) (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Pins and processor side
  input wire flash_write_protect_pin,
  input wire cpu_pc_in_flash,
  // Load and branch
  input wire ram_we,
  input wire [15:0] ram_addr,
  input wire ram_loader_locked,
  input wire cpu_branch,
  input wire [15:0] cpu_branch_addr,
  // Flash control
  input wire flash_read_block,
  input wire [7:0] flash_ctrl_lower,
  input wire [7:0] flash_ctrl_upper,
  input wire swe_ready
);
  logic [10:0] swe_cnt;
  wire busy = |flash_ctrl_lower[1:0] || |flash_ctrl_upper[1:0];
  // Cycles the write enable bit has been held
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) swe_cnt <= 11'h000;
    else if (!flash_ctrl_lower[6]) swe_cnt <= 11'h000;
    else if (swe_cnt != 11'h7FF) swe_cnt <= swe_cnt + 11'h001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_busy_blocks_read: assert property (busy |-> ##[0:1] flash_read_block)
    else $error("flash readable while busy");
  a_idle_frees_read: assert property (!busy [*2] |-> !flash_read_block)
    else $error("flash blocked while idle");
  a_wp_clears_ctrl: assert property (flash_write_protect_pin [*4] |->
    flash_ctrl_lower[5:0] == 6'h00 && flash_ctrl_upper[5:0] == 6'h00)
    else $error("control bits set under write protect");
  a_load_locked: assert property (ram_we |-> ram_loader_locked)
    else $error("load with loader region unlocked");
  a_load_region: assert property (ram_we |->
    ram_addr >= 16'h0800 && ram_addr < 16'h0800 + PROG_LEN)
    else $error("load outside program region");
  a_branch_target: assert property (cpu_branch |-> cpu_branch_addr == 16'h0800 && !ram_we)
    else $error("bad branch target");
  a_branch_unlock: assert property (cpu_branch |=> !ram_loader_locked && !cpu_branch)
    else $error("loader region locked after branch");
  a_swe_settle: assert property (swe_ready |-> swe_cnt >= 11'h3E7)
    else $error("write enable ready too early");
  a_pc_flash_hold: assert property ((cpu_pc_in_flash && !flash_write_protect_pin) [*4] |->
    $stable(flash_ctrl_lower) && $stable(flash_ctrl_upper))
    else $error("control changed from flash code");
  c_branch: cover property (cpu_branch);
  c_swe: cover property (swe_ready);
  c_busy: cover property (flash_read_block);
endmodule // fbe_entry_props

/* test/fbe_host.sv */
// Host model: zero bytes until the sync reply, then 0x55 and the program bytes.
// Assumes 8N1 framing at BIT_CYC clocks per bit; the line idles high.
`timescale 1ns/1ps
module fbe_host #(
  parameter BIT_CYC = 16,
  parameter N = 4
) (
  // Clock and control
  input wire clock,
  input wire start,
  // Serial lines
  input wire txd,
  output logic rxd,
  // Status
  output logic got_sync
);
  logic [7:0] rb;
  int j;
  int n;
  task automatic send(input logic [7:0] b);
    int i;
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge clock);
    for (i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (BIT_CYC) @(posedge clock);
    end
    rxd <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge clock);
  endtask
  // Receive the device replies
  initial begin
    got_sync = 1'b0;
    forever begin
      @(negedge txd);
      repeat (BIT_CYC * 3 / 2) @(posedge clock);
      for (j = 0; j < 8; j++) begin
        rb[j] = txd;
        repeat (BIT_CYC) @(posedge clock);
      end
      if (rb === 8'h00) got_sync = 1'b1;
    end
  end
  // Send the boot traffic
  initial begin
    rxd = 1'b1;
    wait (start === 1'b1);
    while (!got_sync) send(8'h00);
    send(8'h55);
    for (n = 0; n < N; n++) send(8'hA0 + n[7:0]);
  end
endmodule // fbe_host

/* test/tb.sv */
// Testbench: mode decode, serial boot load and flash control registers.
// Assumes a 100 MHz clock and the host model on the serial lines.
`timescale 1ns/1ps
module tb;
  logic clock, sys_rst, wp, go, got_sync, in_flash, serial_rxd, serial_txd;
  logic reg_wr, reg_rd, ram_we, ram_loader_locked, cpu_branch, flash_read_block, swe_ready;
  logic [3:0] md;
  logic [7:0] reg_addr, reg_wdata, ram_wdata, flash_ctrl_lower, flash_ctrl_upper;
  logic [15:0] reg_rdata, ram_addr, cpu_branch_addr, v, vr, rom_rdata;
  int num_errors = 0;
  int checks_done = 0;
  int nld = 0;
  int k;
  logic [3:0] pins [4] = '{4'h1, 4'h4, 4'hB, 4'hC};
  logic [7:0] st [4] = '{8'h13, 8'h15, 8'h1A, 8'h00};
  logic [7:0] msk [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h10};
  fbe_entry #(.PROG_LEN(16'h0004)) i_fbe_entry (.clock(clock), .sys_rst(sys_rst),
    .flash_write_protect_pin(wp), .mode_select_pin3(md[3]), .mode_select_pin2(md[2]),
    .mode_select_pin1(md[1]), .mode_select_pin0(md[0]), .serial_rxd(serial_rxd),
    .serial_txd(serial_txd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .cpu_pc_in_flash(in_flash), .cpu_ram_addr(16'h0000),
    .ram_loader_locked(ram_loader_locked), .cpu_branch(cpu_branch),
    .cpu_branch_addr(cpu_branch_addr), .flash_read_block(flash_read_block),
    .flash_ctrl_lower(flash_ctrl_lower), .flash_ctrl_upper(flash_ctrl_upper),
    .swe_ready(swe_ready));
  fbe_host #(.BIT_CYC(16), .N(4)) i_fbe_host (.clock(clock), .start(go), .txd(serial_txd),
    .rxd(serial_rxd), .got_sync(got_sync));
  fbe_entry #(.FLASH_PRESENT(0), .PROG_LEN(16'h0004)) i_fbe_entry_rom (.clock(clock),
    .sys_rst(sys_rst), .flash_write_protect_pin(wp), .mode_select_pin3(md[3]),
    .mode_select_pin2(md[2]), .mode_select_pin1(md[1]), .mode_select_pin0(md[0]),
    .serial_rxd(serial_rxd), .serial_txd(), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rom_rdata), .ram_we(), .ram_addr(),
    .ram_wdata(), .cpu_pc_in_flash(in_flash), .cpu_ram_addr(16'h0000),
    .ram_loader_locked(), .cpu_branch(), .cpu_branch_addr(), .flash_read_block(),
    .flash_ctrl_lower(), .flash_ctrl_upper(), .swe_ready());
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    v = reg_rdata;
    vr = rom_rdata;
  endtask
  task rst(input logic [3:0] p);
    sys_rst <= 1'b1;
    md <= p;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Every store into RAM must match the next host byte
  always @(posedge clock) begin
    if (ram_we === 1'b1) begin
      check("ram_addr", ram_addr, 16'h0800 + nld[15:0]);
      check("ram_data", {8'h00, ram_wdata}, {8'h00, 8'hA0 + nld[7:0]});
      nld++;
    end
  end
  initial begin
    sys_rst = 1'b1;
    {wp, go, in_flash, reg_wr, reg_rd} = 5'h00;
    {md, reg_addr, reg_wdata} = 20'h00000;
    for (k = 0; k < 4; k++) begin
      rst(pins[k]);
      rd(8'h82);
      check("status", v & {8'h00, msk[k]}, {8'h00, st[k]});
      check("rom_read", vr, 16'h0000);
      check("locked", 16'(ram_loader_locked), 16'(st[k][0]));
      wr(8'h80, 8'h01);
      rd(8'h80);
      check("ctrl_lo", v, 16'(st[k][4]));
    end
    rst(4'h1);
    go <= 1'b1;
    for (k = 0; k < 20000 && cpu_branch !== 1'b1; k++) @(posedge clock);
    check("branch", 16'(cpu_branch), 16'h0001);
    check("branch_addr", cpu_branch_addr, 16'h0800);
    check("loaded", 16'(nld), 16'h0004);
    check("sync_byte", 16'(got_sync), 16'h0001);
    rd(8'h83);
    check("divisor", v, 16'h0010);
    rd(8'h82);
    check("status", v, 16'h0053);
    check("locked", 16'(ram_loader_locked), 16'h0000);
    wr(8'h80, 8'h40);
    repeat (900) @(posedge clock);
    check("swe_early", 16'(swe_ready), 16'h0000);
    repeat (200) @(posedge clock);
    check("swe_ready", 16'(swe_ready), 16'h0001);
    wr(8'h80, 8'h51);
    rd(8'h80);
    check("ctrl_lo", v, 16'h0051);
    check("read_block", 16'(flash_read_block), 16'h0001);
    wr(8'h80, 8'h40);
    wr(8'h81, 8'h7C);
    rd(8'h81);
    check("ctrl_hi", v, 16'h003C);
    check("read_block", 16'(flash_read_block), 16'h0000);
    in_flash <= 1'b1;
    wr(8'h80, 8'h41);
    rd(8'h80);
    check("ctrl_lo", v, 16'h0040);
    in_flash <= 1'b0;
    wp <= 1'b1;
    repeat (4) @(posedge clock);
    wr(8'h80, 8'h41);
    rd(8'h80);
    check("ctrl_lo", v, 16'h0040);
    rd(8'h81);
    check("ctrl_hi", v, 16'h0000);
    rd(8'h10);
    check("unmapped", v, 16'h0000);
    summarize();
  end
  initial begin
    repeat (60000) @(posedge clock);
    num_errors++;
    summarize();
  end
endmodule // tb
bind fbe_entry fbe_entry_props #(.PROG_LEN(PROG_LEN)) i_fbe_entry_props (.clock, .sys_rst,
  .flash_write_protect_pin, .cpu_pc_in_flash, .ram_we, .ram_addr, .ram_loader_locked,
  .cpu_branch, .cpu_branch_addr, .flash_read_block, .flash_ctrl_lower, .flash_ctrl_upper,
  .swe_ready);
